//--- rtl/afc_pkg.sv
/*
  constants and carrier types for the automatic flow controller.
  assumes a 40 mhz core clock and a 32-bit register port at the host.
*/
package afc_pkg;
  localparam logic [7:0] CFG_OFFSET = 8'hAC;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_WMASK = 32'h00FF_FFFF;
  localparam int HI_LSB = 16;
  localparam int LO_LSB = 8;
  localparam int DUR_LSB = 4;
  localparam int MULT_BIT = 3;
  localparam int BRD_BIT = 2;
  localparam int ADD_BIT = 1;
  localparam int ANY_BIT = 0;
  localparam int LEVEL_SHIFT = 6; // thresholds count 64-byte units
  localparam int CLK_MHZ = 40;
  // jam durations in tenths of a microsecond, 100 mb/s then 10 mb/s
  localparam int DUR_FAST_TENTHS [16] = '{50, 100, 150, 250, 500, 1000, 1500, 2000,
    2500, 3000, 3500, 4000, 4500, 5000, 5500, 6000};
  localparam int DUR_SLOW_EXTRA_TENTHS = 22; // 10 mb/s adds 2.2 us
  // cycles = tenths * 40 / 10, rounded down as these are longest times
  localparam int TENTHS_TO_CYC_NUM = CLK_MHZ;
  localparam int TENTHS_TO_CYC_DEN = 10;

  typedef struct packed {
    logic [7:0] high_level;
    logic [7:0] low_level;
    logic [3:0] jam_duration;
    logic jam_on_multicast;
    logic jam_on_broadcast;
    logic jam_on_own_address;
    logic flow_on_any_frame;
  } automatic_flow_control_config_s;

  typedef struct packed {
    logic preamble; // valid preamble seen
    logic multicast;
    logic broadcast;
    logic own_address;
  } afc_rxev_s;
endpackage

//--- rtl/afc_jam_timer.sv
/*
  holds jam (backpressure) for a duration chosen by a 4-bit code.
  assumes start is a one-cycle pulse on core_clk.
*/
`timescale 1ns/100ps
module afc_jam_timer
  import afc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  input wire logic [3:0] code,
  input wire logic speed_100,
  output logic busy
);
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [15:0] load_val;

  function automatic logic [15:0] dur_cycles(input logic [3:0] c, input logic fast);
    int t;
    t = DUR_FAST_TENTHS[c] + (fast ? 0 : DUR_SLOW_EXTRA_TENTHS);
    return 16'((t * TENTHS_TO_CYC_NUM) / TENTHS_TO_CYC_DEN);
  endfunction

  // the start edge is already the first jam cycle, so the count loads one less;
  // a fresh start restarts the whole period
  assign load_val = dur_cycles(code, speed_100);
  assign nxt_cnt = abort ? 16'h0000 : start ? load_val - 16'h0001 :
                   (cnt_ff != 16'h0000) ? cnt_ff - 16'h0001 : 16'h0000;
  assign busy = cnt_ff != 16'h0000;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

//--- rtl/afc_flow_ctrl.sv
/*
  automatic flow controller: config register, threshold watch, pause
  requests in full duplex and timed jam in half duplex.
  assumes rx events and fifo count are on core_clk, and the mac sends
  a requested pause and answers with pause_done.
*/
// Function
// R1: no pause request or jam while the transmitter is disabled
// R2: high level at bits 23:16 in 64-byte units triggers flow control
// R3: full duplex sends one pause frame with the mac pause time at high level
// R4: half duplex jams every matching frame for the set duration after high level
// R5: low level at 15:8; falling below sends a zero-time pause
// R6: resume frame only after a pause was sent and while enabled
// R7: software keeps low level below high level when enabled
// R8: bits 7:4 set jam length, ignored in full duplex
// R9: bit 3 jams multicast frames in half duplex
// R10: bit 2 jams broadcast frames in half duplex
// R11: bit 1 jams frames to own address in half duplex
// R12: bit 0 acts on any frame or immediately, overriding bits 3:1
// R13: code 0 is 5 us at 100 mb/s and 7.2 us at 10 mb/s
// R14: reached means count at least level times 64; rearm after resume
`timescale 1ns/100ps
module afc_flow_ctrl
  import afc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_ff,
  input wire logic [13:0] rx_fifo_bytes,
  input wire afc_rxev_s rx_event,
  input wire logic tx_enabled,
  input wire logic full_duplex,
  input wire logic speed_100,
  input wire logic pause_done,
  output logic pause_req_ff,
  output logic pause_zero_ff,
  output logic jam_ff
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PAUSE = 2'b01,
    ST_HELD = 2'b11,
    ST_RESUME = 2'b10
  } afc_state_e;

  afc_state_e state_ff;
  afc_state_e nxt_state;
  automatic_flow_control_config_s cfg_ff;
  logic [31:0] cfg_word;
  logic cfg_hit;
  logic enabled;
  logic hi_reached;
  logic below_lo;
  logic match_frame;
  logic jam_start;
  logic jam_busy;
  logic any_pause;
  logic nxt_req;
  logic nxt_zero;

  function automatic logic level_ge(input logic [13:0] bytes, input logic [7:0] lvl);
    return {6'h00, bytes} >= ({12'h000, lvl} << LEVEL_SHIFT);
  endfunction

  // register decode; upper byte reserved and reads zero
  assign cfg_hit = reg_addr == CFG_OFFSET;
  assign cfg_word = {8'h00, cfg_ff};
  assign enabled = cfg_ff.flow_on_any_frame | cfg_ff.jam_on_multicast |
                   cfg_ff.jam_on_broadcast | cfg_ff.jam_on_own_address;

  // thresholds; low must sit below high, which software guarantees (see R7)
  assign hi_reached = level_ge(rx_fifo_bytes, cfg_ff.high_level); // see R2 see R14
  assign below_lo = !level_ge(rx_fifo_bytes, cfg_ff.low_level); // see R5

  // frame criteria, any-frame overriding the rest
  assign match_frame = cfg_ff.flow_on_any_frame ? rx_event.preamble : // see R12
    (cfg_ff.jam_on_multicast & rx_event.multicast) | // see R9
    (cfg_ff.jam_on_broadcast & rx_event.broadcast) | // see R10
    (cfg_ff.jam_on_own_address & rx_event.own_address); // see R11
  // half duplex jam only, code ignored in full duplex
  assign jam_start = tx_enabled & !full_duplex & hi_reached & match_frame; // see R4 see R8
  // full duplex pause fires only with any-frame set
  assign any_pause = full_duplex & cfg_ff.flow_on_any_frame & hi_reached; // see R3 see R12

  afc_jam_timer u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(jam_start),
    .abort(!tx_enabled | full_duplex), // see R1
    .code(cfg_ff.jam_duration), // see R13
    .speed_100(speed_100),
    .busy(jam_busy)
  );

  // pause sequencer: one pause at high, one zero-time resume at low
  always_comb begin
    nxt_state = state_ff;
    nxt_req = 1'b0;
    nxt_zero = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (tx_enabled && any_pause) begin
          nxt_state = ST_PAUSE; // see R3
        end
      end
      ST_PAUSE: begin
        nxt_req = tx_enabled;
        if (!tx_enabled) begin
          nxt_state = ST_IDLE; // see R1
        end else if (pause_done) begin
          nxt_state = ST_HELD;
          nxt_req = 1'b0;
        end
      end
      ST_HELD: begin
        if (!enabled) begin
          nxt_state = ST_IDLE; // see R6
        end else if (below_lo && tx_enabled && full_duplex) begin
          nxt_state = ST_RESUME; // see R5
        end
      end
      ST_RESUME: begin
        nxt_req = tx_enabled & enabled;
        nxt_zero = nxt_req;
        if (!tx_enabled || !enabled) begin
          nxt_state = ST_IDLE; // see R1 see R6
        end else if (pause_done) begin
          nxt_state = ST_IDLE; // rearm, see R14
          nxt_req = 1'b0;
          nxt_zero = 1'b0;
        end
      end
    endcase
  end

  // state, outputs and register port
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      cfg_ff <= automatic_flow_control_config_s'(CFG_RESET[23:0]);
      reg_rdata_ff <= 32'h0000_0000;
      pause_req_ff <= 1'b0;
      pause_zero_ff <= 1'b0;
      jam_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (reg_wr && cfg_hit) begin
        cfg_ff <= automatic_flow_control_config_s'(reg_wdata[23:0] & CFG_WMASK[23:0]);
      end
      reg_rdata_ff <= (reg_rd && cfg_hit) ? cfg_word : 32'h0000_0000;
      pause_req_ff <= nxt_req;
      pause_zero_ff <= nxt_zero;
      jam_ff <= (jam_busy | jam_start) & tx_enabled & !full_duplex; // see R1
    end
  end

  no_pause_off_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see R1
    !$past(tx_enabled) |-> !pause_req_ff && !jam_ff)
    else $error("pause or jam while transmitter off");
  jam_on_match_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see R4
    jam_start |=> jam_ff)
    else $error("matching frame not jammed");
  jam_fd_off_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see R8
    $past(full_duplex) |-> !jam_ff)
    else $error("jam in full duplex");
  pause_start_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see R3
    state_ff == ST_IDLE && tx_enabled && any_pause |=> ##1 pause_req_ff && !pause_zero_ff)
    else $error("pause not requested at high level");
  resume_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see R5
    pause_zero_ff |-> pause_req_ff && $past(state_ff) == ST_RESUME)
    else $error("zero pause outside resume");
  resume_after_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see R6
    $rose(pause_zero_ff) |-> $past(state_ff, 2) inside {ST_HELD, ST_RESUME})
    else $error("resume without prior pause");
  any_override_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see R12
    cfg_ff.flow_on_any_frame && !rx_event.preamble && !jam_busy |=> !jam_ff)
    else $error("criteria bits not overridden");
  reach_level_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see R14
    rx_fifo_bytes < {cfg_ff.high_level, 6'h00} |-> !hi_reached)
    else $error("high level reached early");
endmodule

//--- tb/afc_mac_model.sv
/*
  stand-in for the mac transmitter: sends a requested pause frame and
  answers with a one-cycle pause_done. assumes requests are held levels.
*/
`timescale 1ns/100ps
module afc_mac_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pause_req_ff,
  output logic pause_done
);
  logic [3:0] wait_ff;
  // a queued pause waits for a transmit window, so the answer is slow
  always_ff @(posedge core_clk) begin
    wait_ff <= (!rst_n || !pause_req_ff || pause_done) ? 4'h0 : wait_ff + 4'h1;
    pause_done <= rst_n && pause_req_ff && !pause_done && (wait_ff == 4'h9);
  end
endmodule

//--- tb/tb.sv
/*
  bench for the flow controller: register port, pause requests, timed jam.
  assumes afc_mac_model answers pause requests in place of the mac.
*/
`timescale 1ns/100ps
module tb import afc_pkg::*;;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata_ff;
  logic [13:0] rx_fifo_bytes = 14'h0;
  afc_rxev_s rx_event = '0;
  logic tx_enabled = 1'b0;
  logic full_duplex = 1'b1;
  logic speed_100 = 1'b1;
  logic pause_done, pause_req_ff, pause_zero_ff, jam_ff;
  int n_errors = 0;
  int num_checks = 0;
  logic [31:0] rd_val;

  always #12.5 core_clk = ~core_clk;

  afc_flow_ctrl afc_flow_ctrl_i (.core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .rx_fifo_bytes(rx_fifo_bytes), .rx_event(rx_event), .tx_enabled(tx_enabled),
    .full_duplex(full_duplex), .speed_100(speed_100), .pause_done(pause_done),
    .pause_req_ff(pause_req_ff), .pause_zero_ff(pause_zero_ff), .jam_ff(jam_ff));
  afc_mac_model afc_mac_model_i (.core_clk(core_clk), .rst_n(rst_n),
    .pause_req_ff(pause_req_ff), .pause_done(pause_done));

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read data is registered, so look one settle step after the taking edge
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata_ff;
  endtask

  // bounded wait on the pause request; running out ends the run
  task automatic wait_req(input logic v);
    repeat (60) begin
      @(posedge core_clk);
      #1 if (pause_req_ff === v) return;
    end
    check("pause request wait", 32'(pause_req_ff), 32'(v));
    complete_run();
  endtask

  task automatic quiet(input string what, input int cyc);
    int n;
    n = 0;
    // sample first, then end on an edge so the caller's next drive lands on it
    repeat (cyc) begin
      #1 if (pause_req_ff === 1'b1 || jam_ff === 1'b1) n++;
      @(posedge core_clk);
    end
    check(what, 32'(n), 32'h0);
  endtask

  // one received frame, then count how many cycles jam stands
  task automatic jam_run(input string what, input logic [3:0] ev, input int exp);
    int n;
    n = 0;
    @(posedge core_clk);
    rx_event <= ev;
    @(posedge core_clk);
    rx_event <= '0;
    repeat (450) begin
      #1 if (jam_ff === 1'b1) n++;
      @(posedge core_clk);
    end
    check(what, 32'(n), 32'(exp));
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    tx_enabled <= 1'b1;
    rd(8'hAC);
    check("cfg reset", rd_val, CFG_RESET);
    wr(8'hAC, 32'hFFFF_FEFF);
    rd(8'hAC);
    check("cfg fields", rd_val, 32'h00FF_FEFF);
    wr(8'hA8, 32'h0);
    rd(8'hA8);
    check("unmapped read", rd_val, 32'h0);
    rd(8'hAC);
    check("cfg kept", rd_val, 32'h00FF_FEFF);
    // full duplex: high 2, low 1, any frame
    wr(8'hAC, 32'h0002_0101);
    quiet("no resume unarmed", 20);
    rx_fifo_bytes <= 14'd127;
    quiet("below high", 20);
    rx_fifo_bytes <= 14'd128;
    wait_req(1'b1);
    check("pause time kind", 32'(pause_zero_ff), 32'h0);
    wait_req(1'b0);
    quiet("single pause", 30);
    rx_fifo_bytes <= 14'd64;
    quiet("at low", 20);
    rx_fifo_bytes <= 14'd63;
    wait_req(1'b1);
    check("resume zero", 32'(pause_zero_ff), 32'h1);
    wait_req(1'b0);
    // criteria bits do nothing in full duplex
    wr(8'hAC, 32'h0002_0108);
    rx_fifo_bytes <= 14'd200;
    jam_run("fd multicast", 4'hC, 0);
    tx_enabled <= 1'b0;
    wr(8'hAC, 32'h0002_0101);
    quiet("tx off fd", 20);
    full_duplex <= 1'b0;
    jam_run("tx off hd", 4'h8, 0);
    tx_enabled <= 1'b1;
    wr(8'hAC, 32'h0002_0108);
    jam_run("hd broadcast off", 4'hA, 0);
    jam_run("hd multicast", 4'hC, 200);
    wr(8'hAC, 32'h0002_0104);
    jam_run("hd broadcast", 4'hA, 200);
    speed_100 <= 1'b0;
    wr(8'hAC, 32'h0002_0102);
    jam_run("hd own slow", 4'h9, 288);
    speed_100 <= 1'b1;
    wr(8'hAC, 32'h0002_0111);
    jam_run("hd any code1", 4'h8, 400);
    rx_fifo_bytes <= 14'd127;
    jam_run("hd below high", 4'h8, 0);
    complete_run();
  end
endmodule
